// ===== fpcs_consts.svh
// constants for the fault parameter capture store
// Behaviour
// [RL1] capture runs only while setup bit 1 set
// [RL2] captured set returned as 32-byte block read
// [RL3] refresh RAM capture once per firmware cycle
// [RL4] control value 1 copies nonvolatile copy to RAM
// [RL5] control value 2 saves RAM, only when disabled
// [RL6] shutdown-response fault saves capture; retry does not
// [RL7] host disables module and capture before readback
// [RL8] save may take 1400 us; host waits
// [RL9] host never stores capture-enable setting
// [RL10] after power cycle: capture off, value 1, read
// [RL11] init checks nonvolatile store before applying settings; code: reset clears userValid, so init always applies DEFAULT_CFG
// [RL12] default store and user store both provided
// [RL13] restore-defaults reloads from default store
// [RL14] restore only from levels made available to user
// [RL15] value 2 while enabled is ignored
`ifndef FPCS_CONSTS_SVH
`define FPCS_CONSTS_SVH
`define FPCS_CAPTURE_BYTES   32
`define FPCS_CAPTURE_EN_BIT  1
`define FPCS_CTRL_LOAD       8'h01
`define FPCS_CTRL_SAVE       8'h02
`define FPCS_CLK_MHZ         25
`define FPCS_SAVE_TIME_US    1400
`define FPCS_SAVE_CYCLES     (`FPCS_SAVE_TIME_US * `FPCS_CLK_MHZ)
`define FPCS_CFG_BYTES       8
`define FPCS_CMD_MISC        3'h0
`define FPCS_CMD_CONTROL     3'h1
`define FPCS_CMD_READ        3'h2
`define FPCS_CMD_RESTORE_DEF 3'h3
`define FPCS_CMD_RESTORE_USR 3'h4
`define FPCS_CMD_STORE_USR   3'h5
`endif

// ===== fpcs_pkg.sv
// types shared by both ends of the capture store link
package fpcs_pkg;
  typedef enum logic [2:0] {
    FPCS_IDLE  = 3'b000,
    FPCS_LOAD  = 3'b001,
    FPCS_READ  = 3'b011,
    FPCS_SAVE  = 3'b010,
    FPCS_INIT  = 3'b110,
    FPCS_RESTR = 3'b111
  } fpcs_state_type;
endpackage

// ===== fpcs_link_if.sv
// command link between system controller and capture store
`timescale 1ns/1ns
interface fpcs_link_if;
  logic       cmdValid;
  logic [2:0] cmdCode;
  logic [7:0] cmdData;
  logic       cmdReady;
  logic       rdValid;
  logic [7:0] rdData;
  logic       rdLast;
  logic       busy;
  logic       refused;
  modport device (input cmdValid, cmdCode, cmdData,
                  output cmdReady, rdValid, rdData, rdLast, busy, refused);
  modport host   (output cmdValid, cmdCode, cmdData,
                  input cmdReady, rdValid, rdData, rdLast, busy, refused);
endinterface

// ===== fpcs_device.sv
// device end: capture RAM, nonvolatile copy, config stores
`timescale 1ns/1ns
`include "fpcs_consts.svh"
module fpcs_device
  import fpcs_pkg::*;
#(
  parameter int NBYTES      = `FPCS_CAPTURE_BYTES,
  parameter int SAVE_CYCLES = `FPCS_SAVE_CYCLES,
  parameter int CFG_BYTES   = `FPCS_CFG_BYTES,
  parameter logic [CFG_BYTES*8-1:0] DEFAULT_CFG = '0
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // link
  fpcs_link_if.device                 link,
  // power stage side
  input  wire logic                   moduleEnabled,
  input  wire logic                   fwTick,
  input  wire logic [NBYTES*8-1:0]    liveParams,
  input  wire logic                   faultTrip,
  input  wire logic                   faultIsShutdown,
  input  wire logic                   userStoreAllowed,
  // configuration out
  output logic [CFG_BYTES*8-1:0]      activeCfg,
  output logic [7:0]                  miscSetup,
  output logic                        initDone
);
  localparam int CW = $clog2(SAVE_CYCLES + 1);
  localparam int BW = $clog2(NBYTES);

  fpcs_state_type stateReg;
  logic [7:0]     capRam  [NBYTES];
  logic [7:0]     nvCap   [NBYTES];
  logic [CFG_BYTES*8-1:0] userCfg;
  logic           userValid;
  logic [CW-1:0]  waitReg;
  logic [BW-1:0]  idxReg;
  logic           cmdTake;
  logic           captureOn;

  assign captureOn     = miscSetup[`FPCS_CAPTURE_EN_BIT];
  assign link.cmdReady = (stateReg == FPCS_IDLE);
  assign cmdTake       = link.cmdValid && link.cmdReady;
  assign link.busy     = (stateReg != FPCS_IDLE);

  // command sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= FPCS_INIT;
      waitReg  <= '0;
      idxReg   <= '0;
    end else begin
      unique case (stateReg)
        FPCS_INIT: stateReg <= FPCS_IDLE; // see [RL11]
        FPCS_IDLE: begin
          idxReg <= '0;
          if (faultTrip && faultIsShutdown) begin
            stateReg <= FPCS_SAVE; // see [RL6]
            waitReg  <= CW'(SAVE_CYCLES);
          end else if (cmdTake) begin
            unique case (link.cmdCode)
              `FPCS_CMD_CONTROL:
                if (link.cmdData == `FPCS_CTRL_LOAD)
                  stateReg <= FPCS_LOAD; // see [RL4]
                else if (link.cmdData == `FPCS_CTRL_SAVE && !moduleEnabled) begin
                  stateReg <= FPCS_SAVE; // see [RL5] [RL15]
                  waitReg  <= CW'(SAVE_CYCLES);
                end
              `FPCS_CMD_READ: stateReg <= FPCS_READ; // see [RL2]
              default: stateReg <= FPCS_IDLE;
            endcase
          end
        end
        FPCS_LOAD: stateReg <= FPCS_IDLE;
        FPCS_READ: begin
          if (idxReg == BW'(NBYTES - 1))
            stateReg <= FPCS_IDLE;
          idxReg <= idxReg + 1'b1;
        end
        FPCS_SAVE: begin
          // busy spans the whole programming time
          if (waitReg <= CW'(1))
            stateReg <= FPCS_IDLE; // see [RL8]
          waitReg <= waitReg - 1'b1;
        end
        FPCS_RESTR: stateReg <= FPCS_IDLE;
        default: stateReg <= FPCS_IDLE;
      endcase
    end
  end

  // capture RAM: live refresh or reload from nonvolatile copy
  always_ff @(posedge clk) begin
    for (int i = 0; i < NBYTES; i++) begin
      if (stateReg == FPCS_LOAD)
        capRam[i] <= nvCap[i]; // see [RL4]
      else if (captureOn && fwTick)
        capRam[i] <= liveParams[i*8 +: 8]; // see [RL1] [RL3]
    end
  end

  // nonvolatile image written at the end of the save window
  always_ff @(posedge clk) begin
    if (stateReg == FPCS_SAVE && waitReg == CW'(1)) begin
      for (int i = 0; i < NBYTES; i++)
        nvCap[i] <= capRam[i]; // see [RL5] [RL6]
    end
  end

  // block read data, byte 0 first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.rdValid <= 1'b0;
      link.rdData  <= 8'h00;
      link.rdLast  <= 1'b0;
    end else begin
      link.rdValid <= (stateReg == FPCS_READ); // see [RL2]
      link.rdData  <= capRam[idxReg];
      link.rdLast  <= (stateReg == FPCS_READ) && (idxReg == BW'(NBYTES - 1));
    end
  end

  // refused pulse: save while enabled, or restore of an unavailable level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      link.refused <= 1'b0;
    else
      link.refused <= cmdTake && !(faultTrip && faultIsShutdown) &&
        ((link.cmdCode == `FPCS_CMD_CONTROL && link.cmdData == `FPCS_CTRL_SAVE
          && moduleEnabled) || // see [RL15]
         (link.cmdCode == `FPCS_CMD_RESTORE_USR && !(userValid && userStoreAllowed)));
  end

  // setup byte and configuration stores
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      miscSetup <= 8'h00;
      activeCfg <= '0;
      userCfg   <= '0;
      userValid <= 1'b0;
      initDone  <= 1'b0;
    end else begin
      if (stateReg == FPCS_INIT) begin
        // reset clears userValid, so start-up always loads DEFAULT_CFG, never the user store
        activeCfg <= userValid ? userCfg : DEFAULT_CFG; // see [RL11] [RL12]
        initDone  <= 1'b1;
      end
      if (cmdTake && !(faultTrip && faultIsShutdown)) begin
        unique case (link.cmdCode)
          `FPCS_CMD_MISC: miscSetup <= link.cmdData; // see [RL1]
          `FPCS_CMD_RESTORE_DEF: activeCfg <= DEFAULT_CFG; // see [RL13] [RL14]
          `FPCS_CMD_RESTORE_USR:
            if (userValid && userStoreAllowed)
              activeCfg <= userCfg; // see [RL14]
          `FPCS_CMD_STORE_USR: begin
            userCfg   <= activeCfg; // see [RL12]
            userValid <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // fpcs_device

// ===== fpcs_host.sv
// host end: system controller issuing commands and collecting reads
`timescale 1ns/1ns
`include "fpcs_consts.svh"
module fpcs_host
  import fpcs_pkg::*;
#(
  parameter int NBYTES = `FPCS_CAPTURE_BYTES
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // link
  fpcs_link_if.host                link,
  // user request side
  input  wire logic                reqValid,
  input  wire logic [2:0]          reqCode,
  input  wire logic [7:0]          reqData,
  input  wire logic                moduleEnabled,
  output logic                     reqReady,
  output logic                     reqRefused,
  output logic [NBYTES*8-1:0]      readBlock,
  output logic                     readDone
);
  localparam int BW = $clog2(NBYTES);
  logic [BW-1:0] idxReg;
  logic          pendReg;
  logic          blocked;
  logic [7:0]    miscShadowReg;

  // readback needs module and capture off; capture-enable never stored
  assign blocked =
    (reqCode == `FPCS_CMD_CONTROL && reqData == `FPCS_CTRL_LOAD &&
     (moduleEnabled || miscShadowReg[`FPCS_CAPTURE_EN_BIT])) || // see [RL7] [RL10]
    (reqCode == `FPCS_CMD_STORE_USR && miscShadowReg[`FPCS_CAPTURE_EN_BIT]); // see [RL9]
  assign reqReady = !pendReg && !link.busy; // see [RL8]

  // command issue, one outstanding at a time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pendReg       <= 1'b0;
      link.cmdValid <= 1'b0;
      link.cmdCode  <= 3'h0;
      link.cmdData  <= 8'h00;
      miscShadowReg <= 8'h00;
      reqRefused    <= 1'b0;
    end else begin
      reqRefused <= reqValid && reqReady && blocked;
      if (link.cmdValid && link.cmdReady) begin
        link.cmdValid <= 1'b0;
        pendReg       <= 1'b0;
      end else if (reqValid && reqReady && !blocked) begin
        link.cmdValid <= 1'b1;
        link.cmdCode  <= reqCode;
        link.cmdData  <= reqData;
        pendReg       <= 1'b1;
        if (reqCode == `FPCS_CMD_MISC)
          miscShadowReg <= reqData;
      end
    end
  end

  // assemble the block read, byte 0 in the low lane
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idxReg    <= '0;
      readBlock <= '0;
      readDone  <= 1'b0;
    end else begin
      readDone <= link.rdValid && link.rdLast; // see [RL2]
      if (link.rdValid) begin
        readBlock[idxReg*8 +: 8] <= link.rdData;
        idxReg <= link.rdLast ? '0 : idxReg + 1'b1;
      end
    end
  end
endmodule // fpcs_host

// ===== fpcs_link_props.sv
// checker for the link between host end and device end
`timescale 1ns/1ns
`include "fpcs_consts.svh"
module fpcs_link_props #(
  parameter int SAVE_CYCLES = 20
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // link signals
  input wire logic       cmdValid,
  input wire logic [2:0] cmdCode,
  input wire logic [7:0] cmdData,
  input wire logic       cmdReady,
  input wire logic       rdValid,
  input wire logic       rdLast,
  input wire logic       busy,
  input wire logic       refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire        take = cmdValid && cmdReady;
  wire        ctrl = take && cmdCode == `FPCS_CMD_CONTROL;
  logic [5:0] byteCnt;
  logic [31:0] runCnt;
  logic       saveSeen;
  logic       prevBusy;
  // byte count within a burst, busy run length, and whether the run is a commanded save
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byteCnt <= '0;
      runCnt <= '0;
      saveSeen <= 1'b0;
      prevBusy <= 1'b0;
    end else begin
      byteCnt <= rdValid ? byteCnt + 6'h01 : 6'h00;
      runCnt <= busy ? runCnt + 1 : 0;
      prevBusy <= busy;
      // a refused save never starts a run, so it must not arm the length check
      if (refused || (prevBusy && !busy)) saveSeen <= 1'b0;
      else if (ctrl && cmdData == `FPCS_CTRL_SAVE) saveSeen <= 1'b1;
    end
  end
  property p_readStart; take && cmdCode == `FPCS_CMD_READ |-> ##2 rdValid; endproperty
  a_readStart: assert property (p_readStart) else $error("read burst late");
  property p_lastCount; rdLast |-> rdValid && byteCnt == 6'h1F; endproperty
  a_lastCount: assert property (p_lastCount) else $error("last byte misplaced");
  property p_contig; $rose(rdValid) |-> rdValid [*8]; endproperty
  a_contig: assert property (p_contig) else $error("read burst gap");
  property p_loadBusy; ctrl && cmdData == `FPCS_CTRL_LOAD |=> busy ##1 !busy; endproperty
  a_loadBusy: assert property (p_loadBusy) else $error("load length wrong");
  property p_saveBusy; ctrl && cmdData == `FPCS_CTRL_SAVE ##1 !refused |-> busy [*8]; endproperty
  a_saveBusy: assert property (p_saveBusy) else $error("save not held busy");
  // busy is sampled high on exactly SAVE_CYCLES edges after the take edge
  property p_saveLen; saveSeen && prevBusy && !busy |-> runCnt == SAVE_CYCLES; endproperty
  a_saveLen: assert property (p_saveLen) else $error("save length wrong");
  property p_refPulse; refused |-> $past(take) ##1 !refused; endproperty
  a_refPulse: assert property (p_refPulse) else $error("refusal pulse wrong");
  property p_refNoSave; ctrl && cmdData == `FPCS_CTRL_SAVE ##1 refused |-> !busy; endproperty
  a_refNoSave: assert property (p_refNoSave) else $error("refused save ran");
endmodule // fpcs_link_props

// ===== fault_parameter_capture_store_tb_top.sv
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ns
`include "fpcs_consts.svh"
module fault_parameter_capture_store_tb_top;
  import fpcs_pkg::*;
  localparam logic [63:0]  DEF = 64'h0123456789ABCDEF;
  localparam logic [255:0] PA  = {8{32'h33221100}};
  localparam logic [255:0] PB  = {8{32'hA5B6C7D8}};
  localparam logic [255:0] PC  = {8{32'h0F1E2D3C}};
  localparam logic [255:0] PD  = {8{32'hC3F00F3C}};
  logic         clk, reset_n, reqValid, moduleEnabled, fwTick, faultTrip, faultShut, userOk;
  logic [2:0]   reqCode;
  logic [7:0]   reqData, miscSetup;
  logic [255:0] live, readBlock;
  logic [63:0]  activeCfg;
  logic         reqReady, readDone, initDone;
  int           miscompares, compares, cyc, refCnt, busyCnt, doneCnt, r0;
  fpcs_link_if link ();
  fpcs_device #(.SAVE_CYCLES(20), .DEFAULT_CFG(DEF)) fpcs_device_i (.clk(clk),
    .reset_n(reset_n), .link(link), .moduleEnabled(moduleEnabled), .fwTick(fwTick),
    .liveParams(live), .faultTrip(faultTrip), .faultIsShutdown(faultShut),
    .userStoreAllowed(userOk), .activeCfg(activeCfg), .miscSetup(miscSetup), .initDone(initDone));
  fpcs_host fpcs_host_i (.clk(clk), .reset_n(reset_n), .link(link), .reqValid(reqValid),
    .reqCode(reqCode), .reqData(reqData), .moduleEnabled(moduleEnabled), .reqReady(reqReady),
    .reqRefused(), .readBlock(readBlock), .readDone(readDone));
  fpcs_link_props #(.SAVE_CYCLES(20)) fpcs_link_props_i (.clk(clk), .reset_n(reset_n),
    .cmdValid(link.cmdValid), .cmdCode(link.cmdCode), .cmdData(link.cmdData),
    .cmdReady(link.cmdReady), .rdValid(link.rdValid), .rdLast(link.rdLast),
    .busy(link.busy), .refused(link.refused));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // event counters and hang guard; the run needs well under 4000 cycles
  always @(posedge clk) begin
    cyc++;
    refCnt += (link.refused === 1'b1);
    busyCnt += (link.busy === 1'b1);
    doneCnt += (readDone === 1'b1);
    if (cyc == 4000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // wait for the device to start and finish, bounded since refusals never go busy
  task automatic idle();
    int n;
    n = 0;
    while (link.busy !== 1'b1 && n < 4) begin
      step();
      n++;
    end
    while (link.busy === 1'b1 && n < 200) begin
      step();
      n++;
    end
    step();
    step();
  endtask
  // request held until the host takes it
  task automatic req(input logic [2:0] c, input logic [7:0] d);
    int n;
    n = 0;
    reqValid = 1'b1;
    reqCode = c;
    reqData = d;
    while (reqReady !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    step();
    reqValid = 1'b0;
    idle();
  endtask
  task automatic rd(input logic [255:0] exp);
    r0 = doneCnt;
    req(`FPCS_CMD_READ, 8'h00);
    chk(doneCnt - r0, 1);
    chk(readBlock, exp);
  endtask
  task automatic tick(input logic [255:0] p);
    live = p;
    fwTick = 1'b1;
    step();
    fwTick = 1'b0;
    step();
  endtask
  task automatic fault(input logic shut);
    faultShut = shut;
    faultTrip = 1'b1;
    step();
    faultTrip = 1'b0;
    idle();
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence: capture gating, refused and real saves, fault saves, restores
  initial begin
    {reqValid, moduleEnabled, fwTick, faultTrip, faultShut, userOk, reset_n} = '0;
    reqCode = 3'h0;
    reqData = 8'h00;
    live = '0;
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    step();
    step();
    chk(initDone, 1);
    chk(activeCfg, DEF);
    req(`FPCS_CMD_MISC, 8'h02);
    chk(miscSetup[`FPCS_CAPTURE_EN_BIT], 1);
    tick(PA);
    rd(PA);
    tick(PB);
    rd(PB);
    req(`FPCS_CMD_MISC, 8'h00);
    tick(PC);
    rd(PB);
    moduleEnabled = 1'b1;
    {r0, busyCnt} = {refCnt, 32'h0};
    req(`FPCS_CMD_CONTROL, `FPCS_CTRL_SAVE);
    chk(refCnt - r0, 1);
    chk(busyCnt, 0);
    moduleEnabled = 1'b0;
    busyCnt = 0;
    req(`FPCS_CMD_CONTROL, `FPCS_CTRL_SAVE);
    // the save window is exactly the programming time at the sim rate
    chk(busyCnt, 20);
    req(`FPCS_CMD_MISC, 8'h02);
    tick(PD);
    req(`FPCS_CMD_MISC, 8'h00);
    req(`FPCS_CMD_CONTROL, `FPCS_CTRL_LOAD);
    rd(PB);
    req(`FPCS_CMD_MISC, 8'h02);
    tick(PA);
    fault(1'b0);
    req(`FPCS_CMD_MISC, 8'h00);
    req(`FPCS_CMD_CONTROL, `FPCS_CTRL_LOAD);
    rd(PB);
    req(`FPCS_CMD_MISC, 8'h02);
    tick(PC);
    fault(1'b1);
    tick(PD);
    req(`FPCS_CMD_MISC, 8'h00);
    req(`FPCS_CMD_CONTROL, `FPCS_CTRL_LOAD);
    rd(PC);
    req(`FPCS_CMD_RESTORE_DEF, 8'h00);
    chk(activeCfg, DEF);
    r0 = refCnt;
    req(`FPCS_CMD_RESTORE_USR, 8'h00);
    chk(refCnt - r0, 1);
    conclude();
  end
endmodule // fault_parameter_capture_store_tb_top
